/* verilog/uart_tx_pkg.sv */
// package with register map, field positions, reset values and carrier types of the uart transmit dma block
package uart_tx_pkg;
  // ********************************
  // sizes
  // ********************************
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int ADDR_W = 8;
  localparam logic [CNT_W-1:0] FIFO_FULL_COUNT = 7'h40;
  localparam logic [CNT_W-1:0] TRIG_COARSE_SHIFT = 7'h02;

  // ********************************
  // register offsets (byte addresses)
  // ********************************
  localparam logic [ADDR_W-1:0] OFF_TX_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EFR_FCR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LINE_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MODEM_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TRIG_SCRATCH = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_SUPPL_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_MODE_DEF_THREE = 8'h80;
  localparam logic [ADDR_W-1:0] OFF_TX_THRESH = 8'h84;
  localparam logic [ADDR_W-1:0] OFF_FIFO_STATUS = 8'h90;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h94;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h98;

  // ********************************
  // field positions and key values
  // ********************************
  localparam logic [7:0] LCR_FEATURE_PORTAL = 8'hbf;
  localparam int LCR_DIVISOR_BIT = 7;
  localparam int EFR_ENHANCED_BIT = 4;
  localparam int MCR_TRIG_ACCESS_BIT = 6;
  localparam int SCR_FINE_STEP_BIT = 6;
  localparam int MODE_DEF_REG_THREE_THRESH_EN_BIT = 2;
  localparam int FCR_TX_CLEAR_BIT = 2;
  localparam int FCR_DMA_EN_BIT = 3;
  localparam int FCR_TRIG_LSB = 4;
  localparam int TLR_TX_LSB = 0;
  localparam int THRESH_W = 6;
  localparam int STAT_FULL_BIT = 8;
  localparam int STAT_REQ_BIT = 9;
  localparam int IRQ_W = 3;
  localparam int IRQ_SYNC_ERR = 0;
  localparam int IRQ_FULL = 1;
  localparam int IRQ_REQ_RISE = 2;

  // ********************************
  // reset values
  // ********************************
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // ********************************
  // carrier types
  // ********************************
  typedef struct packed {
    logic [7:0] enhanced_feature_reg;
    logic [7:0] line_ctrl_portal_reg;
    logic [7:0] modem_ctrl_reg;
    logic [7:0] tlr;
    logic [7:0] spr;
    logic [7:0] suppl_ctrl_reg;
    logic [7:0] mode_def_reg_three;
    logic [7:0] tx_xfer_thresh_reg;
    logic [7:0] fifo_ctrl_reg;
    logic [IRQ_W-1:0] irq_mask;
  } uart_regs_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } bus_req_t;

  localparam uart_regs_t REGS_RESET = '{REG8_RESET, REG8_RESET, REG8_RESET, REG8_RESET, REG8_RESET,
    REG8_RESET, REG8_RESET, REG8_RESET, REG8_RESET, IRQ_RESET};
endpackage

/* verilog/tx_fifo_store.sv */
// storage array of the transmit fifo with a registered read port
`timescale 1ns/1ps
module tx_fifo_store
  import uart_tx_pkg::*;
(
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [uart_tx_pkg::PTR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [uart_tx_pkg::PTR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:FIFO_DEPTH-1];

  // write port and registered read port
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

/* verilog/uart_tx_dma_threshold.sv */
// transmit fifo, threshold logic and dma request of the uart, with an avalon-mm register slave
// How it works
// R01: 64-entry fifo, full flag at 64
// R02: request built in bus clock domain
// R03: surplus request would cause sync error
// R04: software keeps threshold plus trigger within 63
// R05: line control BFh opens enhanced feature register
// R06: enhanced bit 4 unlocks modem control writes
// R07: line control 00h reaches fifo control
// R08: supplementary bit 6 gives one-entry trigger step
// R09: modem bit 6 exposes trigger level register
// R10: zero tlr, fcr field 1 means trigger 1
// R11: mode register bit 2 selects programmed threshold
// R12: threshold is six bits, 3Eh means 62
// R13: full flag resynchronised before gating requests; here the request is gated on next_full, with no resynchroniser
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module uart_tx_dma_threshold
  import uart_tx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [uart_tx_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic tx_xfer_request_line,
  output logic tx_fifo_full,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  input wire logic tx_byte_ready,
  output logic irq
);
  import uart_tx_pkg::*;

  // ********************************
  // declarations
  // ********************************
  bus_req_t req;
  uart_regs_t regs, next_regs;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic accept, push, clear_fifo, w1c_en;
  logic enhanced_access_on, tx_trig_fine_step, trig_visible;
  logic [CNT_W-1:0] trig_level, thresh;
  logic [CNT_W-1:0] count, next_count;
  logic [PTR_W-1:0] wptr, next_wptr, rptr, next_rptr;
  logic next_full, push_ok, rd_en, pend, next_pend, next_byte_valid, next_req;
  logic [7:0] rd_data, next_byte;
  logic [IRQ_W-1:0] irq_status, next_irq_status, events;
  logic next_irq;

  assign req = '{avs_address, avs_read, avs_write, avs_byteenable, avs_writedata};
  assign accept = (req.read | req.write) & ~avs_waitrequest;
  assign enhanced_access_on = regs.enhanced_feature_reg[EFR_ENHANCED_BIT];
  assign tx_trig_fine_step = regs.suppl_ctrl_reg[SCR_FINE_STEP_BIT];
  assign trig_visible = enhanced_access_on & regs.modem_ctrl_reg[MCR_TRIG_ACCESS_BIT];

  // ********************************
  // trigger level and threshold
  // ********************************
  // trigger count from tlr and fcr fields; coarse mode steps by four entries
  always_comb
  begin
    trig_level = {1'b0, regs.tlr[TLR_TX_LSB +: 4], regs.fifo_ctrl_reg[FCR_TRIG_LSB +: 2]};
    if (!tx_trig_fine_step) // R08
    begin
      trig_level = CNT_W'(trig_level << TRIG_COARSE_SHIFT);
    end
    if (trig_level == '0)
    begin
      trig_level = CNT_W'(1); // R10
    end
    if (regs.mode_def_reg_three[MODE_DEF_REG_THREE_THRESH_EN_BIT]) // R11
    begin
      thresh = {1'b0, regs.tx_xfer_thresh_reg[THRESH_W-1:0]}; // R12
    end
    else
    begin
      thresh = FIFO_FULL_COUNT - trig_level;
    end
  end

  // ********************************
  // register slave
  // ********************************
  // decode, read capture, write commit; one wait cycle per access
  always_comb
  begin
    next_regs = regs;
    next_readdata = avs_readdata;
    next_waitrequest = 1'b1;
    push = 1'b0;
    clear_fifo = 1'b0;
    w1c_en = 1'b0;
    if ((req.read | req.write) & avs_waitrequest)
    begin
      next_waitrequest = 1'b0;
      next_readdata = RDATA_RESET;
      if (req.address == OFF_EFR_FCR)
      begin
        if (regs.line_ctrl_portal_reg == LCR_FEATURE_PORTAL)
        begin
          next_readdata[7:0] = regs.enhanced_feature_reg;
        end
        else
        begin
          next_readdata[7:0] = regs.fifo_ctrl_reg;
        end
      end
      else if (req.address == OFF_LINE_CTRL)
      begin
        next_readdata[7:0] = regs.line_ctrl_portal_reg;
      end
      else if (req.address == OFF_MODEM_CTRL)
      begin
        next_readdata[7:0] = regs.modem_ctrl_reg;
      end
      else if (req.address == OFF_TRIG_SCRATCH)
      begin
        next_readdata[7:0] = trig_visible ? regs.tlr : regs.spr; // R09
      end
      else if (req.address == OFF_SUPPL_CTRL)
      begin
        next_readdata[7:0] = regs.suppl_ctrl_reg;
      end
      else if (req.address == OFF_MODE_DEF_THREE)
      begin
        next_readdata[7:0] = regs.mode_def_reg_three;
      end
      else if (req.address == OFF_TX_THRESH)
      begin
        next_readdata[7:0] = regs.tx_xfer_thresh_reg;
      end
      else if (req.address == OFF_FIFO_STATUS)
      begin
        next_readdata[CNT_W-1:0] = count;
        next_readdata[STAT_FULL_BIT] = tx_fifo_full;
        next_readdata[STAT_REQ_BIT] = tx_xfer_request_line;
      end
      else if (req.address == OFF_IRQ_STATUS)
      begin
        next_readdata[IRQ_W-1:0] = irq_status;
      end
      else if (req.address == OFF_IRQ_MASK)
      begin
        next_readdata[IRQ_W-1:0] = regs.irq_mask;
      end
    end
    next_regs.fifo_ctrl_reg[FCR_TX_CLEAR_BIT] = 1'b0; // clear bit is self-clearing
    if (accept & req.write & req.byteenable[0])
    begin
      if (req.address == OFF_TX_DATA)
      begin
        push = 1'b1;
      end
      else if (req.address == OFF_EFR_FCR)
      begin
        if (regs.line_ctrl_portal_reg == LCR_FEATURE_PORTAL) // R05
        begin
          next_regs.enhanced_feature_reg = req.writedata[7:0];
        end
        else if (!regs.line_ctrl_portal_reg[LCR_DIVISOR_BIT]) // R07
        begin
          next_regs.fifo_ctrl_reg = req.writedata[7:0];
          clear_fifo = req.writedata[FCR_TX_CLEAR_BIT];
        end
      end
      else if (req.address == OFF_LINE_CTRL)
      begin
        next_regs.line_ctrl_portal_reg = req.writedata[7:0];
      end
      else if (req.address == OFF_MODEM_CTRL)
      begin
        next_regs.modem_ctrl_reg = req.writedata[7:0];
        if (!enhanced_access_on) // R06
        begin
          next_regs.modem_ctrl_reg[MCR_TRIG_ACCESS_BIT] = regs.modem_ctrl_reg[MCR_TRIG_ACCESS_BIT];
        end
      end
      else if (req.address == OFF_TRIG_SCRATCH)
      begin
        if (trig_visible) // R09
        begin
          next_regs.tlr = req.writedata[7:0];
        end
        else
        begin
          next_regs.spr = req.writedata[7:0];
        end
      end
      else if (req.address == OFF_SUPPL_CTRL)
      begin
        next_regs.suppl_ctrl_reg = req.writedata[7:0];
      end
      else if (req.address == OFF_MODE_DEF_THREE)
      begin
        next_regs.mode_def_reg_three = req.writedata[7:0];
      end
      else if (req.address == OFF_TX_THRESH)
      begin
        next_regs.tx_xfer_thresh_reg = req.writedata[7:0];
      end
      else if (req.address == OFF_IRQ_STATUS)
      begin
        w1c_en = 1'b1;
      end
      else if (req.address == OFF_IRQ_MASK)
      begin
        next_regs.irq_mask = req.writedata[IRQ_W-1:0];
      end
    end
  end

  // register the slave state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regs <= REGS_RESET;
      avs_readdata <= RDATA_RESET;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      regs <= next_regs;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // ********************************
  // transmit fifo and dma request
  // ********************************
  tx_fifo_store u_store (
    .core_clk(core_clk),
    .wr_en(push_ok),
    .wr_addr(wptr),
    .wr_data(req.writedata[7:0]),
    .rd_en(rd_en),
    .rd_addr(rptr),
    .rd_data(rd_data)
  );

  // fill count, pointers, output byte and request level
  always_comb
  begin
    push_ok = push & ~tx_fifo_full; // a push into a full fifo is dropped
    rd_en = (~tx_byte_valid | tx_byte_ready) & ~pend & (count != '0);
    next_wptr = wptr + PTR_W'(push_ok);
    next_rptr = rptr + PTR_W'(rd_en);
    next_count = count + CNT_W'(push_ok) - CNT_W'(rd_en);
    next_pend = rd_en;
    next_byte = pend ? rd_data : tx_byte;
    next_byte_valid = pend | (tx_byte_valid & ~tx_byte_ready);
    if (clear_fifo)
    begin
      next_wptr = '0;
      next_rptr = '0;
      next_count = '0;
      next_pend = 1'b0;
      next_byte_valid = 1'b0;
    end
    next_full = (next_count == FIFO_FULL_COUNT); // R01
    // gate on the full state that registers with the request, so no surplus pulse
    next_req = regs.fifo_ctrl_reg[FCR_DMA_EN_BIT] & ~next_full & (next_count <= thresh); // R02 R13
  end

  // register the fifo state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      wptr <= '0;
      rptr <= '0;
      pend <= 1'b0;
      tx_byte <= REG8_RESET;
      tx_byte_valid <= 1'b0;
      tx_fifo_full <= 1'b0;
      tx_xfer_request_line <= 1'b0;
    end
    else
    begin
      count <= next_count;
      wptr <= next_wptr;
      rptr <= next_rptr;
      pend <= next_pend;
      tx_byte <= next_byte;
      tx_byte_valid <= next_byte_valid;
      tx_fifo_full <= next_full;
      tx_xfer_request_line <= next_req;
    end
  end

  // ********************************
  // interrupts
  // ********************************
  // sticky events, write one to clear, a new event wins over the clear
  always_comb
  begin
    events = '0;
    events[IRQ_SYNC_ERR] = push & tx_fifo_full; // R03
    events[IRQ_FULL] = next_full & ~tx_fifo_full;
    events[IRQ_REQ_RISE] = next_req & ~tx_xfer_request_line;
    next_irq_status = irq_status;
    if (w1c_en)
    begin
      next_irq_status = irq_status & ~req.writedata[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_regs.irq_mask);
  end

  // register interrupt state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status <= IRQ_RESET;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_FULL_AT_DEPTH: assert property (tx_fifo_full == (count == FIFO_FULL_COUNT)) // R01
    else $error("full flag does not match a count of 64");
  AST_NO_REQ_WHEN_FULL: assert property (tx_fifo_full |-> !tx_xfer_request_line) // R02 R13
    else $error("dma request high while fifo full");
  AST_SYNC_ERR_FLAG: assert property ((push && tx_fifo_full) |=> irq_status[IRQ_SYNC_ERR]) // R03
    else $error("push into full fifo did not flag a sync error");
  AST_PORTAL_EFR: assert property ((accept && req.write && req.byteenable[0] && req.address == OFF_EFR_FCR
    && regs.line_ctrl_portal_reg == LCR_FEATURE_PORTAL) |=> regs.enhanced_feature_reg == $past(req.writedata[7:0]) && $stable(regs.fifo_ctrl_reg)) // R05
    else $error("portal write did not reach the enhanced feature register");
  AST_MCR_LOCK: assert property ((accept && req.write && req.address == OFF_MODEM_CTRL && !enhanced_access_on)
    |=> $stable(regs.modem_ctrl_reg[MCR_TRIG_ACCESS_BIT])) // R06
    else $error("locked modem control bit changed");
  AST_FCR_NORMAL: assert property ((accept && req.write && req.byteenable[0] && req.address == OFF_EFR_FCR
    && regs.line_ctrl_portal_reg == REG8_RESET) |=> regs.fifo_ctrl_reg[7:3] == $past(req.writedata[7:3]) && $stable(regs.enhanced_feature_reg)) // R07
    else $error("normal access write did not reach fifo control");
  AST_FINE_TRIG_ONE: assert property ((tx_trig_fine_step && regs.tlr[3:0] == 4'h0
    && regs.fifo_ctrl_reg[5:4] == 2'h1) |-> trig_level == CNT_W'(1)) // R08 R10
    else $error("fine trigger level is not one");
  AST_TLR_READ: assert property ((avs_read && avs_waitrequest && avs_address == OFF_TRIG_SCRATCH && trig_visible)
    |=> !avs_waitrequest && avs_readdata[7:0] == $past(regs.tlr)) // R09
    else $error("trigger level register not visible");
  AST_THRESH_SEL: assert property (regs.mode_def_reg_three[MODE_DEF_REG_THREE_THRESH_EN_BIT] |-> thresh == {1'b0, regs.tx_xfer_thresh_reg[5:0]}) // R11 R12
    else $error("programmed threshold not in use");
endmodule

/* verif/dma_refill_model.sv */
// behavioural model of the system dma controller that refills the transmit fifo
`timescale 1ns/1ps
module dma_refill_model
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic req,
  input wire logic waitreq,
  output logic busy,
  output logic [7:0] wdata
);
  int gap;
  // ********************************
  // one byte write per request, held until waitrequest is sampled low
  // ********************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      wdata <= 8'h00;
      gap <= 1;
    end
    else if (busy)
    begin
      if (!waitreq)
      begin
        busy <= 1'b0;
        wdata <= ~wdata; // released data does not keep its last value
        gap <= 1 + ($urandom % 3); // at least one idle cycle so the request level is seen fresh
      end
    end
    else if (gap > 0)
      gap <= gap - 1;
    else if (en && req)
    begin
      busy <= 1'b1;
      wdata <= 8'($urandom);
    end
  end
endmodule

/* verif/uart_tx_dma_threshold_bench.sv */
// self-checking bench of the uart transmit fifo and dma request block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module uart_tx_dma_threshold_bench;
  import uart_tx_pkg::*;
  logic core_clk, rst_n, b_read, b_write, ready, dma_en, drain;
  logic [7:0] b_addr, tx_byte, p_data, exp_b;
  localparam logic [7:0] RST_ADDRS [6] = '{8'h0c, 8'h10, 8'h40, 8'h80, 8'h84, 8'h44};
  logic [31:0] b_wdata, readdata, q;
  logic waitreq, req, full, valid, irq, p_busy;
  logic [7:0] exp_q[$];
  int checks, fails, cycles, n;
  // ********************************
  // bus sharing: the dma model owns the bus while it has a write open
  // ********************************
  uart_tx_dma_threshold uart_tx_dma_threshold_inst (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(p_busy ? OFF_TX_DATA : b_addr), .avs_read(b_read), .avs_write(p_busy | b_write),
    .avs_byteenable(4'h1), .avs_writedata(p_busy ? {24'h0, p_data} : b_wdata), .avs_readdata(readdata),
    .avs_waitrequest(waitreq), .tx_xfer_request_line(req), .tx_fifo_full(full), .tx_byte(tx_byte),
    .tx_byte_valid(valid), .tx_byte_ready(ready), .irq(irq));
  dma_refill_model dma_refill_model_inst (.core_clk(core_clk), .rst_n(rst_n), .en(dma_en), .req(req),
    .waitreq(waitreq), .busy(p_busy), .wdata(p_data));
  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // scoreboard of pushed bytes, random serializer stall and hang limit
  always @(posedge core_clk)
  begin
    if ((p_busy || b_write) && !waitreq && uart_tx_dma_threshold_inst.avs_address == OFF_TX_DATA && !full)
      exp_q.push_back(uart_tx_dma_threshold_inst.avs_writedata[7:0]);
    if (valid && ready)
    begin
      exp_b = exp_q.pop_front(); // pop once, the check macro names its arguments twice
      `CHK(tx_byte, exp_b)
    end
    ready <= drain ? 1'($urandom % 2) : 1'b0;
    cycles++;
    if (cycles > 40000)
    begin
      fails++;
      close_out();
    end
  end
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int k;
    k = 0;
    b_addr <= a;
    b_write <= wr;
    b_read <= !wr;
    b_wdata <= d;
    @(posedge core_clk);
    while (waitreq !== 1'b0 && k < 50)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 50)
      fails++;
    q = readdata;
    b_read <= 1'b0;
    b_write <= 1'b0;
    @(posedge core_clk);
  endtask
  // wait until the dma model stops refilling
  task automatic settle();
    n = 0;
    while ((req === 1'b1 || p_busy) && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
  endtask
  task automatic drain_all();
    drain <= 1'b1;
    n = 0;
    while ((exp_q.size() > 0 || valid) && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    drain <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    rst_n = 1'b0;
    {b_read, b_write, dma_en, drain, ready} = 5'h00;
    b_addr = 8'h00;
    b_wdata = 32'h0;
    checks = 0;
    fails = 0;
    cycles = 0;
    void'($urandom(59));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // reset values, then an unmapped place
    foreach (RST_ADDRS[i])
    begin
      bus(RST_ADDRS[i], 1'b0, 32'h0);
      `CHK(q, 32'h0)
    end
    bus(OFF_MODEM_CTRL, 1'b1, 32'h40);
    bus(OFF_MODEM_CTRL, 1'b0, 32'h0);
    `CHK(q[6], 1'b0)
    bus(OFF_LINE_CTRL, 1'b1, 32'hbf);
    bus(OFF_EFR_FCR, 1'b1, 32'h10);
    bus(OFF_EFR_FCR, 1'b0, 32'h0);
    `CHK(q[7:0], 8'h10)
    bus(OFF_LINE_CTRL, 1'b1, 32'h00);
    bus(OFF_EFR_FCR, 1'b1, 32'h18);
    bus(OFF_SUPPL_CTRL, 1'b1, 32'h40);
    bus(OFF_MODEM_CTRL, 1'b1, 32'h40);
    bus(OFF_MODEM_CTRL, 1'b0, 32'h0);
    `CHK(q[7:0], 8'h40)
    bus(OFF_TRIG_SCRATCH, 1'b1, 32'h00);
    bus(OFF_MODE_DEF_THREE, 1'b1, 32'h04);
    bus(OFF_TX_THRESH, 1'b1, 32'h3e);
    bus(OFF_TX_THRESH, 1'b0, 32'h0);
    `CHK(q[5:0], 6'h3e)
    bus(OFF_IRQ_MASK, 1'b1, 32'h1);
    // dma fills up to threshold 62 plus one, never to full
    dma_en <= 1'b1;
    settle();
    dma_en <= 1'b0;
    settle();
    bus(OFF_FIFO_STATUS, 1'b0, 32'h0);
    `CHK(q, 32'h0000_003f)
    `CHK(irq, 1'b0)
    // bench pushes to full, then one push too many
    bus(OFF_TX_DATA, 1'b1, {24'h0, 8'($urandom)});
    `CHK(full, 1'b1)
    bus(OFF_FIFO_STATUS, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0140)
    bus(OFF_TX_DATA, 1'b1, 32'h5a);
    `CHK(irq, 1'b1)
    bus(OFF_IRQ_STATUS, 1'b0, 32'h0);
    `CHK(q[2:0], 3'h7)
    bus(OFF_IRQ_STATUS, 1'b1, 32'h7);
    `CHK(irq, 1'b0)
    drain_all();
    bus(OFF_FIFO_STATUS, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0200)
    // threshold from trigger level one: fills to full, then random traffic
    bus(OFF_MODE_DEF_THREE, 1'b1, 32'h00);
    dma_en <= 1'b1;
    settle();
    bus(OFF_FIFO_STATUS, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0140)
    drain <= 1'b1;
    repeat (3000) @(posedge core_clk);
    dma_en <= 1'b0;
    settle();
    drain_all();
    `CHK(exp_q.size(), 0)
    close_out();
  end
endmodule
